// ### hw/pwm_defs.vh
/*
 Register offsets, field positions, reset values and counts of the standard PWM generator.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH

// Byte addresses of the main registers
`define OFS_MODULE_CONTROL 8'h00
`define OFS_DUTY_BUFFER 8'h04
`define OFS_DUTY_ACTIVE 8'h08
`define OFS_TIMER_SELECT 8'h0C

// Timer n sits at byte 8'h10 * (n + 1); word offsets inside its slot
`define TMR_OFS_PERIOD 4'h0
`define TMR_OFS_CONTROL 4'h4
`define TMR_OFS_COUNT 4'h8
`define TMR_OFS_FLAG 4'hC
`define NUM_TIMERS 3

// Module control fields
`define CTRL_DUTY_HI 5
`define CTRL_DUTY_LO 4
`define CTRL_PWM_HI 3
`define CTRL_PWM_LO 2
`define MODE_PWM 2'h3

// Timer selection register fields
`define TSEL_HI 1
`define TSEL_DIR_BIT 4
`define TSEL_NONE 2'h3

// Timer control fields and prescale codes
`define TCTL_PS_HI 1
`define TCTL_RUN_BIT 2
`define TCTL_HI 6
`define PS_1 2'h0
`define PS_4 2'h1
`define PRE_LIM_1 4'h0
`define PRE_LIM_4 4'h3
`define PRE_LIM_16 4'hF

// Four oscillator phases per timer increment
`define PHASE_LAST 2'h3

// Reset values
`define RST_BYTE 8'h00
`define RST_DIR 1'b1

`endif

// ### hw/standard_pwm_generator.v
/*
 Standard PWM generator with three 8-bit period timers and an Avalon-MM register slave.
 Assumes clk is the oscillator clock, ce low means sleep, and all inputs share clk.
*/
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "pwm_defs.vh"

//
// How it works
// - Compare logic runs only on clk; with ce low nothing advances.
// - One output pin carries the waveform, duty resolution up to 10 bits.
// - Module control written all zero releases the pin and drives its latch low.
// - A 2-bit source select picks one of three 8-bit period timers.
// - Period is (period_reg + 1) x 4 x clock period x prescale.
// - On the increment after count equals period_reg the count clears.
// - At each period boundary the pin goes high unless duty is zero.
// - At each period boundary the buffered duty moves into the active duty.
// - Postscaler bits have no influence on the PWM period.
// - Duty is duty_buffer_reg as eight MSBs and control bits 5:4 as LSBs.
// - Duty writes take effect only after the current period ends.
// - In PWM mode writes to the active duty register are ignored.
// - High time is duty x clock period x prescale.
// - Time base is count extended by clock phase or prescaler bits.
// - Pin goes low when the time base reaches the latched duty.
// - A pulse longer than the period leaves the pin unchanged.
// - With ce low the timer and all state freeze; pin holds its level.
//
module standard_pwm_generator (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	output reg pwm_output_pin_r,
	output reg pwm_output_pin_oe_r
);

// ****************************************
// Bus access decode
// ****************************************
wire wr_en;
wire [7:0] wd;
wire tmr_area;
wire [1:0] aidx;
wire [3:0] sub;

assign wr_en = ce & write & ~waitrequest & byteenable[0];
assign wd = writedata[7:0];
assign tmr_area = (address[7:6] == 2'h0) & (address[5:4] != 2'h0);
assign aidx = address[5:4] - 2'h1;
assign sub = address[3:0];

// ****************************************
// Control registers
// ****************************************
reg [7:0] module_control_reg_r;
reg [7:0] duty_buffer_reg_r;
reg [7:0] duty_active_reg_r;
reg [1:0] duty_latch_r;
reg [1:0] timer_source_select_r;
reg pin_direction_bit_r;
reg [1:0] phase_r;

wire pwm_mode;
wire ctrl_zero;

assign pwm_mode = module_control_reg_r[`CTRL_PWM_HI:`CTRL_PWM_LO] == `MODE_PWM;
assign ctrl_zero = module_control_reg_r == `RST_BYTE;

always @(posedge clk) begin
	if (!rstn) begin
		module_control_reg_r <= `RST_BYTE;
		duty_buffer_reg_r <= `RST_BYTE;
		timer_source_select_r <= 2'h0;
		pin_direction_bit_r <= `RST_DIR;
	end else if (wr_en) begin
		if (address == `OFS_MODULE_CONTROL) begin
			module_control_reg_r <= wd;
		end else if (address == `OFS_DUTY_BUFFER) begin
			duty_buffer_reg_r <= wd;
		end else if (address == `OFS_TIMER_SELECT) begin
			timer_source_select_r <= wd[`TSEL_HI:0];
			pin_direction_bit_r <= wd[`TSEL_DIR_BIT];
		end
	end
end

// Oscillator phase: four clocks make one timer increment
always @(posedge clk) begin
	if (!rstn) begin
		phase_r <= 2'h0;
	end else if (ce) begin
		phase_r <= phase_r + 2'h1;
	end
end

// ****************************************
// Period timers
// ****************************************
wire [7:0] t_per_w [0:2];
wire [7:0] t_ctl_w [0:2];
wire [7:0] t_cnt_w [0:2];
wire t_flag_w [0:2];
wire t_wrap_w [0:2];
wire t_step_w [0:2];
wire [9:0] t_tb_w [0:2];

genvar i;
generate
	for (i = 0; i < `NUM_TIMERS; i = i + 1) begin : g_tmr
		reg [7:0] period_reg_r;
		reg [6:0] period_timer_control_r;
		reg [7:0] period_timer_count_r;
		reg [3:0] pre_r;
		reg timer_match_flag_r;
		reg [3:0] lim;
		reg [1:0] tb_lo;
		reg step;
		wire hit;
		wire run;
		wire [1:0] ps;
		wire inst;
		wire tick;
		wire wrap;

		assign hit = tmr_area & ({30'h0, aidx} == i);
		assign run = period_timer_control_r[`TCTL_RUN_BIT];
		assign ps = period_timer_control_r[`TCTL_PS_HI:0];
		assign inst = run & (phase_r == `PHASE_LAST);
		assign tick = inst & (pre_r == lim);
		assign wrap = tick & (period_timer_count_r == period_reg_r);

		// Prescale limit, time base low bits and time base step
		always @* begin
			lim = `PRE_LIM_16;
			tb_lo = pre_r[3:2];
			step = inst & (pre_r[1:0] == 2'h3);
			if (ps == `PS_1) begin
				lim = `PRE_LIM_1;
				tb_lo = phase_r;
				step = run;
			end else if (ps == `PS_4) begin
				lim = `PRE_LIM_4;
				tb_lo = pre_r[1:0];
				step = inst;
			end
		end

		always @(posedge clk) begin
			if (!rstn) begin
				period_reg_r <= `RST_BYTE;
				period_timer_control_r <= 7'h00;
				period_timer_count_r <= `RST_BYTE;
				pre_r <= 4'h0;
				timer_match_flag_r <= 1'b0;
			end else if (ce) begin
				if (wr_en & hit & (sub == `TMR_OFS_PERIOD)) begin
					period_reg_r <= wd;
				end
				if (wr_en & hit & (sub == `TMR_OFS_CONTROL)) begin
					period_timer_control_r <= wd[`TCTL_HI:0];
				end
				if (wr_en & hit & (sub == `TMR_OFS_COUNT)) begin
					period_timer_count_r <= wd;
					pre_r <= 4'h0;
				end else begin
					if (inst) begin
						pre_r <= (pre_r == lim) ? 4'h0 : pre_r + 4'h1;
					end
					if (wrap) begin
						period_timer_count_r <= `RST_BYTE;
					end else if (tick) begin
						period_timer_count_r <= period_timer_count_r + 8'h01;
					end
				end
				if (wrap) begin
					timer_match_flag_r <= 1'b1;
				end else if (wr_en & hit & (sub == `TMR_OFS_FLAG) & wd[0]) begin
					timer_match_flag_r <= 1'b0;
				end
			end
		end

		assign t_per_w[i] = period_reg_r;
		assign t_ctl_w[i] = {1'b0, period_timer_control_r};
		assign t_cnt_w[i] = period_timer_count_r;
		assign t_flag_w[i] = timer_match_flag_r;
		assign t_wrap_w[i] = wrap;
		assign t_step_w[i] = step;
		assign t_tb_w[i] = {period_timer_count_r, tb_lo};
	end
endgenerate

// ****************************************
// PWM output stage
// ****************************************
wire src_ok;
wire sel_wrap;
wire sel_step;
wire [9:0] tb_next;
wire [9:0] duty_cur;
wire [9:0] duty_new;

assign src_ok = timer_source_select_r != `TSEL_NONE;
assign sel_wrap = src_ok & t_wrap_w[timer_source_select_r];
assign sel_step = src_ok & t_step_w[timer_source_select_r];
assign tb_next = t_tb_w[timer_source_select_r] + 10'h001;
assign duty_cur = {duty_active_reg_r, duty_latch_r};
assign duty_new = {duty_buffer_reg_r,
	module_control_reg_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO]};

always @(posedge clk) begin
	if (!rstn) begin
		pwm_output_pin_r <= 1'b0;
		pwm_output_pin_oe_r <= 1'b0;
		duty_active_reg_r <= `RST_BYTE;
		duty_latch_r <= 2'h0;
	end else if (ce) begin
		pwm_output_pin_oe_r <= pwm_mode & ~pin_direction_bit_r;
		if (ctrl_zero) begin
			pwm_output_pin_r <= 1'b0;
		end else if (pwm_mode & sel_wrap) begin
			duty_active_reg_r <= duty_buffer_reg_r;
			duty_latch_r <= module_control_reg_r[`CTRL_DUTY_HI:`CTRL_DUTY_LO];
			pwm_output_pin_r <= duty_new != 10'h000;
		end else if (pwm_mode & sel_step & (tb_next == duty_cur)) begin
			pwm_output_pin_r <= 1'b0;
		end
		if (wr_en & (address == `OFS_DUTY_ACTIVE) & ~pwm_mode) begin
			duty_active_reg_r <= wd;
		end
	end
end

// ****************************************
// Avalon-MM slave
// ****************************************
reg [7:0] rd_nxt;

always @* begin
	rd_nxt = 8'h00;
	if (address == `OFS_MODULE_CONTROL) begin
		rd_nxt = module_control_reg_r;
	end else if (address == `OFS_DUTY_BUFFER) begin
		rd_nxt = duty_buffer_reg_r;
	end else if (address == `OFS_DUTY_ACTIVE) begin
		rd_nxt = duty_active_reg_r;
	end else if (address == `OFS_TIMER_SELECT) begin
		rd_nxt = {3'h0, pin_direction_bit_r, 2'h0, timer_source_select_r};
	end else if (tmr_area & (aidx != `TSEL_NONE)) begin
		if (sub == `TMR_OFS_PERIOD) begin
			rd_nxt = t_per_w[aidx];
		end else if (sub == `TMR_OFS_CONTROL) begin
			rd_nxt = t_ctl_w[aidx];
		end else if (sub == `TMR_OFS_COUNT) begin
			rd_nxt = t_cnt_w[aidx];
		end else if (sub == `TMR_OFS_FLAG) begin
			rd_nxt = {7'h00, t_flag_w[aidx]};
		end
	end
end

// Each access: waitrequest drops one cycle after the request, then rises again
always @(posedge clk) begin
	if (!rstn) begin
		waitrequest <= 1'b1;
		readdata <= 32'h0000_0000;
	end else if (ce) begin
		if ((read | write) & waitrequest) begin
			waitrequest <= 1'b0;
			readdata <= read ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
		end else begin
			waitrequest <= 1'b1;
		end
	end
end

endmodule

// ### bench/pwm_load.sv
/* Load at the PWM pin: measures high time, period and edge count.
 Assumes clk is the generator clock; a pull-down holds a released pin low. */
`timescale 1ns/1ns
module pwm_load (
	input wire clk,
	input wire pin,
	input wire oe,
	output logic [11:0] high_len = 12'h000,
	output logic [11:0] period_len = 12'h000,
	output logic [11:0] edges = 12'h000
);
	// ********
	// Measure
	// ********
	logic lvl_d = 1'b0;
	logic [11:0] run = 12'h000;
	logic [11:0] per = 12'h000;
	wire lvl = oe ? pin : 1'b0;
	always @(posedge clk) begin
		lvl_d <= lvl;
		run <= lvl ? run + 12'h001 : 12'h000;
		if (lvl_d && !lvl)
			high_len <= run;
		if (lvl != lvl_d)
			edges <= edges + 12'h001;
		if (lvl && !lvl_d) begin
			period_len <= per;
			per <= 12'h001;
		end else
			per <= per + 12'h001;
	end
endmodule

// ### bench/pwm_checker_assertions.sv
/* Bus and pin checks of the PWM generator.
 Assumes binding to standard_pwm_generator. */
`timescale 1ns/1ns
module pwm_checker (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire read,
	input wire write,
	input wire [7:0] address,
	input wire [3:0] byteenable,
	input wire [31:0] writedata,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire pwm_output_pin_r,
	input wire pwm_output_pin_oe_r
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ********
	// Checks
	// ********
	property p_answer; ce && waitrequest && (read || write) |=> !waitrequest; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_gap; ce && !waitrequest |=> waitrequest; endproperty
	a_gap: assert property (p_gap) else $error("answer too long");
	property p_cause; $fell(waitrequest) |-> $past(read || write); endproperty
	a_cause: assert property (p_cause) else $error("answer without request");
	property p_upper; !waitrequest |-> readdata[31:8] == 24'h00_0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_hold; waitrequest && !read && !write |=> $stable(readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_release;
		write && !waitrequest && address == 8'h00 && byteenable[0] && writedata[7:0] == 8'h00
		|-> ##2 !pwm_output_pin_oe_r && !pwm_output_pin_r;
	endproperty
	a_release: assert property (p_release) else $error("pin not released");
	property p_sleep; !ce |=> $stable(pwm_output_pin_r) && $stable(pwm_output_pin_oe_r); endproperty
	a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
	property p_stall; !ce && waitrequest |=> waitrequest; endproperty
	a_stall: assert property (p_stall) else $error("bus ran in sleep");
endmodule
bind standard_pwm_generator pwm_checker i_chk (.clk, .rstn, .ce, .read, .write, .address,
	.byteenable, .writedata, .readdata, .waitrequest, .pwm_output_pin_r, .pwm_output_pin_oe_r);

// ### bench/test_standard_pwm_generator.sv
/* Register-level tests of the PWM generator.
 Assumes pwm_load at the pin and the checker bound to the design. */
`timescale 1ns/1ns
module test_standard_pwm_generator;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] writedata = 32'h0000_0000;
	wire [31:0] readdata;
	wire waitrequest, pin, oe;
	wire [11:0] high_len, period_len, edges;
	int failures = 0, checks_done = 0;
	logic [7:0] rv, b;
	logic [11:0] e;
	standard_pwm_generator i_dut (.clk, .rstn, .ce, .address, .read, .write, .byteenable,
		.writedata, .readdata, .waitrequest, .pwm_output_pin_r(pin), .pwm_output_pin_oe_r(oe));
	pwm_load i_load (.clk, .pin, .oe, .high_len, .period_len, .edges);
	initial forever #4 clk = ~clk;
	// ********
	// Tasks
	// ********
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input [11:0] got, input [11:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task acc(input logic w, input [7:0] a, input [7:0] d);
		int n;
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, d};
		read <= !w;
		write <= w;
		n = 0;
		@(posedge clk);
		while (waitrequest !== 1'b0) begin
			n++;
			if (n > 100) begin
				failures++;
				end_of_test;
			end
			@(posedge clk);
		end
		rv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		acc(1'b1, a, d);
	endtask
	task rd(input [7:0] a, input [7:0] x);
		acc(1'b0, a, 8'h00);
		chk({4'h0, rv}, {4'h0, x});
	endtask
	task steady(input logic lv);
		repeat (600) @(posedge clk);
		e = edges;
		repeat (300) @(posedge clk);
		chk(edges, e);
		chk({11'h000, pin}, {11'h000, lv});
	endtask
	// ********
	// Tests
	// ********
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h0C, 8'h10);
		chk({10'h000, oe, pin}, 12'h000);
		wr(8'hFC, 8'hAA);
		rd(8'hFC, 8'h00);
		wr(8'h00, 8'h1C);
		wr(8'h04, 8'h02);
		for (int n = 0; n < 3; n++) begin
			b = {2'h0, 2'(n + 1), 4'h0};
			wr(8'h0C, 8'h10 | 8'(n));
			wr(b, 8'h03);
			wr(b + 8'h0C, 8'h01);
			wr(b + 8'h04, 8'h7C | 8'(n));
			rv = 8'h00;
			for (int k = 0; k < 200 && rv[0] !== 1'b1; k++)
				acc(1'b0, b + 8'h0C, 8'h00);
			chk({11'h000, rv[0]}, 12'h001);
			wr(8'h0C, 8'(n));
			repeat (64 << (2 * n)) @(posedge clk);
			chk(period_len, 12'(16 << (2 * n)));
			chk(high_len, 12'(9 << (2 * n)));
			chk({11'h000, oe}, 12'h001);
		end
		wr(8'h34, 8'h02);
		wr(8'h08, 8'h55);
		rd(8'h08, 8'h02);
		wr(8'h04, 8'h01);
		rd(8'h08, 8'h02);
		wr(8'h34, 8'h06);
		repeat (600) @(posedge clk);
		rd(8'h08, 8'h01);
		chk(high_len, 12'h050);
		wr(8'h04, 8'h00);
		wr(8'h00, 8'h0C);
		steady(1'b0);
		wr(8'h04, 8'hFF);
		wr(8'h00, 8'h3C);
		steady(1'b1);
		wr(8'h04, 8'h02);
		wr(8'h00, 8'h1C);
		repeat (600) @(posedge clk);
		ce <= 1'b0;
		e = edges;
		repeat (300) @(posedge clk);
		chk(edges, e);
		ce <= 1'b1;
		repeat (600) @(posedge clk);
		chk(period_len, 12'h100);
		wr(8'h00, 8'h00);
		repeat (2) @(posedge clk);
		chk({10'h000, oe, pin}, 12'h000);
		end_of_test;
	end
	initial begin
		#200000;
		failures++;
		end_of_test;
	end
endmodule
